//--- interrupt_source_vectoring_tb.sv
module interrupt_source_vectoring_tb import isv_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, sys_rst, lv_sel, int_en, sw_break, ack, sdone, slow;
    logic [19:0] src;
    logic [3:0] rst_src;
    logic [28:0] mask, plow;
    logic [34:0] fclr, flags;
    logic [1:0] insvc;
    isv_grant_t grant;
    int err_total, check_count, cyc;
    logic [4:0] slot_tab [20] = '{5'h00, 5'h01, 5'h02, 5'h02, 5'h03, 5'h03, 5'h04, 5'h05, 5'h06,
        5'h07, 5'h08, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0e, 5'h0f};
    logic [15:0] vec_tab [20] = '{16'h0004, 16'h0006, 16'h0008, 16'h0008, 16'h000a, 16'h000a,
        16'h000c, 16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0014, 16'h0016, 16'h0018,
        16'h001a, 16'h001c, 16'h001e, 16'h0020, 16'h0020, 16'h0022};
    isv_top u_isv_top (.mclk, .sys_rst, .low_voltage_irq(src[0]), .low_voltage_mode_select(lv_sel),
        .ext_pin0_irq(src[1]), .ext_pin1_irq(src[2]), .twowire_done_irq(src[3]),
        .ext_pin3_irq(src[4]), .ext_pin4_irq(src[5]), .timer0_ch0_irq(src[6]),
        .timer0_ch1_irq(src[7]), .timer1_ch0_irq(src[8]), .timer1_ch1_irq(src[9]),
        .netctl_error_irq(src[10]), .netctl_wakeup_irq(src[11]), .netctl_rx_done_irq(src[12]),
        .netctl_tx_done_irq(src[13]), .serial0_edge_irq(src[14]), .serial0_rx_irq(src[15]),
        .serial0_tx_irq(src[16]), .ext_pin2_irq(src[17]), .clocked_serial_tx_irq(src[18]),
        .upper_slot_irq({13'h0, src[19]}), .reset_src(rst_src), .mask, .prio_low(plow),
        .int_enable(int_en), .software_break_instr(sw_break), .flag_clear(fclr), .ack,
        .service_done(sdone), .flags, .grant, .in_service(insvc));
    isv_core_model u_isv_core_model (.mclk, .sys_rst, .grant, .slow, .ack);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pulse(logic [19:0] s);
        @(posedge mclk);
        src <= s;
        @(posedge mclk);
        src <= '0;
    endtask
    task automatic wait_grant();
        // never trust a valid seen in the launch step of an edge
        @(negedge mclk);
        for (int n = 0; n < 50 && grant.valid !== 1'b1; n++)
            @(negedge mclk);
        chk("offer", 16'h1, {15'h0, grant.valid});
    endtask
    task automatic retire(logic [34:0] c);
        for (int n = 0; n < 20 && grant.valid === 1'b1; n++)
            @(negedge mclk);
        @(posedge mclk);
        fclr <= c;
        sdone <= 1'b1;
        @(posedge mclk);
        fclr <= '0;
        sdone <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic t_table();
        for (int i = 0; i < 20; i++) begin
            pulse(20'h1 << i);
            wait_grant();
            chk("slot", {11'h0, slot_tab[i]}, {11'h0, grant.slot});
            chk("vector", vec_tab[i], grant.vector);
            chk("flag", 16'h1, {15'h0, flags[i]});
            retire(35'h1 << i);
        end
    endtask
    task automatic t_shared();
        pulse(20'h0c);
        wait_grant();
        chk("shared slot", 16'h2, {11'h0, grant.slot});
        chk("shared vector", 16'h0008, grant.vector);
        repeat (3) @(negedge mclk);
        chk("both flags", 16'h3, {14'h0, flags[3:2]});
        retire(35'h0c);
    endtask
    task automatic t_prio();
        @(posedge mclk);
        int_en <= 1'b0;
        lv_sel <= 1'b1;
        slow <= 1'b1;
        pulse(20'h241);
        repeat (8) @(negedge mclk);
        chk("held off", 16'h0, {15'h0, grant.valid});
        chk("lvi as reset", 16'h0, {15'h0, flags[0]});
        @(posedge mclk);
        int_en <= 1'b1;
        wait_grant();
        chk("first slot", 16'h4, {11'h0, grant.slot});
        retire(35'h40);
        wait_grant();
        chk("second slot", 16'h7, {11'h0, grant.slot});
        retire(35'h200);
        lv_sel <= 1'b0;
        slow <= 1'b0;
    endtask
    task automatic t_mask();
        @(posedge mclk);
        mask <= 29'h10;
        pulse(20'h40);
        repeat (8) @(negedge mclk);
        chk("masked", 16'h0, {15'h0, grant.valid});
        chk("flag kept", 16'h1, {15'h0, flags[6]});
        @(posedge mclk);
        mask <= '0;
        wait_grant();
        chk("unmasked slot", 16'h4, {11'h0, grant.slot});
        retire(35'h40);
    endtask
    task automatic t_nest();
        plow <= 29'h10;
        pulse(20'h40);
        wait_grant();
        chk("low group", 16'h0, {15'h0, grant.high_group});
        pulse(20'h200);
        wait_grant();
        chk("nested slot", 16'h7, {11'h0, grant.slot});
        @(posedge mclk);
        int_en <= 1'b0;
        sw_break <= 1'b1;
        @(posedge mclk);
        sw_break <= 1'b0;
        wait_grant();
        chk("break vector", 16'h003e, grant.vector);
        chk("break kind", 16'h1, {15'h0, grant.is_break});
        chk("both in service", 16'h3, {14'h0, insvc});
        retire(35'h200);
        chk("high retired", 16'h1, {14'h0, insvc});
        retire(35'h40);
        chk("none in service", 16'h0, {14'h0, insvc});
        int_en <= 1'b1;
        plow <= '0;
    endtask
    task automatic t_reset();
        @(posedge mclk);
        rst_src <= 4'h8;
        @(posedge mclk);
        rst_src <= 4'h0;
        wait_grant();
        chk("reset vector", 16'h0, grant.vector);
        chk("reset kind", 16'h1, {15'h0, grant.is_reset});
        retire('0);
    endtask
    initial begin
        {sys_rst, int_en} = 2'h3;
        {lv_sel, sw_break, sdone, slow} = 4'h0;
        {src, rst_src, mask, plow, fclr} = '0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        t_table();
        t_shared();
        t_prio();
        t_mask();
        t_nest();
        t_reset();
        results();
    end
endmodule // interrupt_source_vectoring_tb
bind isv_top isv_props u_isv_props (.mclk, .sys_rst, .low_voltage_irq, .low_voltage_mode_select,
    .timer0_ch0_irq, .int_enable, .software_break_instr, .ack, .flags, .grant);

//--- isv_arbiter.sv
module isv_arbiter import isv_pkg::*; (
    // slot requests
    input wire logic [ISV_SLOTS-1:0] req,
    input wire logic [ISV_SLOTS-1:0] prio_low,
    input wire logic allow_high,
    input wire logic allow_low,
    // winner
    output logic found,
    output logic [ISV_SLOT_W-1:0] win_slot,
    output logic win_low
);
    // ****************************************
    // fixed order scan, high group before low group, lowest index wins within a group
    // ****************************************
    always_comb begin
        found = 1'b0;
        win_slot = '0;
        win_low = 1'b0;
        // high group first, then low, each in default order
        for (int i = ISV_SLOTS - 1; i >= 0; i--) begin
            if (req[i] && !prio_low[i] && allow_high) begin
                found = 1'b1;
                win_slot = ISV_SLOT_W'(i);
                win_low = 1'b0;
            end
        end
        if (!found) begin
            for (int j = ISV_SLOTS - 1; j >= 0; j--) begin
                if (req[j] && prio_low[j] && allow_low) begin
                    found = 1'b1;
                    win_slot = ISV_SLOT_W'(j);
                    win_low = 1'b1;
                end
            end
        end
    end
endmodule // isv_arbiter

//--- isv_core_model.sv
// ****************************************
// core side: takes offers
// ****************************************
module isv_core_model import isv_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // offer and answer
    input wire isv_grant_t grant,
    input wire logic slow,
    output logic ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;
    // slow mode answers three cycles late to stress the standing offer
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ack <= 1'b0;
            wait_cnt <= 2'h0;
        end else begin
            ack <= grant.valid && !ack && (!slow || wait_cnt == 2'h3);
            wait_cnt <= !grant.valid ? 2'h0 : (wait_cnt == 2'h3 ? wait_cnt : wait_cnt + 2'h1);
        end
    end
endmodule // isv_core_model

//--- isv_pkg.sv
package isv_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int ISV_SLOTS = 29;
    localparam int ISV_SLOT_W = 5;
    localparam int ISV_SRC = 35;
    localparam int ISV_VEC_W = 16;
    localparam int ISV_RESET_SRC = 4;

    // ****************************************
    // vectors
    // ****************************************
    localparam logic [15:0] ISV_VEC_RESET = 16'h0000;
    localparam logic [15:0] ISV_VEC_BASE = 16'h0004;
    localparam logic [15:0] ISV_VEC_BREAK = 16'h003e;
    localparam logic [15:0] ISV_VEC_STEP = 16'h0002;

    // ****************************************
    // source bit positions in the request vector
    // ****************************************
    localparam int SRC_LVI = 0;
    localparam int SRC_P0 = 1;
    localparam int SRC_P1 = 2;
    localparam int SRC_IIC = 3;
    localparam int SRC_P3 = 4;
    localparam int SRC_P4 = 5;
    localparam int SRC_T0C0 = 6;
    localparam int SRC_T0C1 = 7;
    localparam int SRC_T1C0 = 8;
    localparam int SRC_T1C1 = 9;
    localparam int SRC_NERR = 10;
    localparam int SRC_NWUP = 11;
    localparam int SRC_NRX = 12;
    localparam int SRC_NTX = 13;
    localparam int SRC_S0E = 14;
    localparam int SRC_S0R = 15;
    localparam int SRC_S0T = 16;
    localparam int SRC_P2 = 17;
    localparam int SRC_CSI = 18;
    localparam int SRC_EXT = 19;

    localparam logic [1:0] ISV_NO_SERVICE = 2'h0;

    typedef struct packed {
        logic valid;
        logic is_break;
        logic is_reset;
        logic high_group;
        logic [4:0] slot;
        logic [15:0] vector;
    } isv_grant_t;

    typedef enum logic [1:0] {ISV_IDLE, ISV_OFFER, ISV_WAIT_ACK} isv_state_t;

endpackage

//--- isv_props.sv
// ****************************************
// grant checks
// ****************************************
module isv_props import isv_pkg::*; (
    // watched ports
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic low_voltage_irq,
    input wire logic low_voltage_mode_select,
    input wire logic timer0_ch0_irq,
    input wire logic int_enable,
    input wire logic software_break_instr,
    input wire logic ack,
    input wire logic [ISV_SRC-1:0] flags,
    input wire isv_grant_t grant
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_break_taken: assert property (software_break_instr |-> ##[1:40] (grant.valid && grant.is_break))
        else $error("break not offered");
    chk_break_vec: assert property (grant.valid && grant.is_break |-> grant.vector == 16'h003e)
        else $error("break vector wrong");
    chk_slot_vec: assert property (grant.valid && !grant.is_break && !grant.is_reset
        |-> grant.vector == 16'h0004 + {10'h000, grant.slot, 1'b0})
        else $error("slot vector wrong");
    chk_reset_vec: assert property (grant.valid && grant.is_reset |-> grant.vector == 16'h0000)
        else $error("reset vector wrong");
    chk_enable_gate: assert property ($rose(grant.valid) && !grant.is_break
        && !grant.is_reset |-> $past(int_enable))
        else $error("offer while disabled");
    chk_lvi_mode: assert property ($rose(flags[0])
        |-> $past(low_voltage_irq) && !$past(low_voltage_mode_select))
        else $error("low voltage flag wrong");
    chk_flag_set: assert property (timer0_ch0_irq |=> flags[6])
        else $error("flag not set");
    chk_offer_stands: assert property (grant.valid && !ack |=> grant.valid && $stable(grant))
        else $error("offer dropped");
    chk_ack_gap: assert property (grant.valid && ack |=> !grant.valid [*2])
        else $error("offer too soon");
endmodule // isv_props

//--- isv_top.sv
module isv_top import isv_pkg::*; #(
    parameter bit HAS_NETCTL = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // peripheral requests, already on mclk
    input wire logic low_voltage_irq,
    input wire logic low_voltage_mode_select,
    input wire logic twowire_done_irq,
    input wire logic timer0_ch0_irq,
    input wire logic timer0_ch1_irq,
    input wire logic timer1_ch0_irq,
    input wire logic timer1_ch1_irq,
    input wire logic netctl_error_irq,
    input wire logic netctl_wakeup_irq,
    input wire logic netctl_rx_done_irq,
    input wire logic netctl_tx_done_irq,
    input wire logic serial0_edge_irq,
    input wire logic serial0_rx_irq,
    input wire logic serial0_tx_irq,
    input wire logic clocked_serial_tx_irq,
    input wire logic [ISV_SLOTS-16:0] upper_slot_irq,
    // external pin edge requests, asynchronous
    input wire logic ext_pin0_irq,
    input wire logic ext_pin1_irq,
    input wire logic ext_pin2_irq,
    input wire logic ext_pin3_irq,
    input wire logic ext_pin4_irq,
    // reset sources
    input wire logic [ISV_RESET_SRC-1:0] reset_src,
    // control from core
    input wire logic [ISV_SLOTS-1:0] mask,
    input wire logic [ISV_SLOTS-1:0] prio_low,
    input wire logic int_enable,
    input wire logic software_break_instr,
    input wire logic [ISV_SRC-1:0] flag_clear,
    input wire logic ack,
    input wire logic service_done,
    // to core
    output logic [ISV_SRC-1:0] flags,
    output isv_grant_t grant,
    output logic [1:0] in_service
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [4:0] pin_s1, pin_s2, next_pin_s1, next_pin_s2;
    always_comb begin
        next_pin_s1 = {ext_pin4_irq, ext_pin3_irq, ext_pin2_irq, ext_pin1_irq, ext_pin0_irq};
        next_pin_s2 = pin_s1;
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= next_pin_s1;
            pin_s2 <= next_pin_s2;
        end
    end

    // ****************************************
    // request flags, set beats clear
    // ****************************************
    logic [ISV_SRC-1:0] raw, next_flags;
    always_comb begin
        raw = '0;
        // low-voltage is maskable only while mode select is 0
        raw[SRC_LVI] = low_voltage_irq && !low_voltage_mode_select;
        raw[SRC_P0] = pin_s2[0];
        raw[SRC_P1] = pin_s2[1];
        raw[SRC_IIC] = twowire_done_irq;
        raw[SRC_P3] = pin_s2[3];
        raw[SRC_P4] = pin_s2[4];
        raw[SRC_T0C0] = timer0_ch0_irq;
        raw[SRC_T0C1] = timer0_ch1_irq;
        raw[SRC_T1C0] = timer1_ch0_irq;
        raw[SRC_T1C1] = timer1_ch1_irq;
        // network sources vanish when the controller is absent
        raw[SRC_NERR] = HAS_NETCTL && netctl_error_irq;
        raw[SRC_NWUP] = HAS_NETCTL && netctl_wakeup_irq;
        raw[SRC_NRX] = HAS_NETCTL && netctl_rx_done_irq;
        raw[SRC_NTX] = HAS_NETCTL && netctl_tx_done_irq;
        raw[SRC_S0E] = serial0_edge_irq;
        raw[SRC_S0R] = serial0_rx_irq;
        raw[SRC_S0T] = serial0_tx_irq;
        raw[SRC_P2] = pin_s2[2];
        raw[SRC_CSI] = clocked_serial_tx_irq;
        raw[SRC_EXT +: ISV_SLOTS-15] = upper_slot_irq;
        // a pending set survives a clear in the same cycle
        next_flags = (flags & ~flag_clear) | raw;
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // ****************************************
    // slot merge
    // ****************************************
    logic [ISV_SLOTS-1:0] slot_req;
    always_comb begin
        slot_req = '0;
        slot_req[0] = flags[SRC_LVI];
        slot_req[1] = flags[SRC_P0];
        slot_req[2] = flags[SRC_P1] | flags[SRC_IIC];
        slot_req[3] = flags[SRC_P3] | flags[SRC_P4];
        slot_req[4] = flags[SRC_T0C0];
        slot_req[5] = flags[SRC_T0C1];
        slot_req[6] = flags[SRC_T1C0];
        slot_req[7] = flags[SRC_T1C1];
        slot_req[8] = flags[SRC_NERR] | flags[SRC_NWUP];
        slot_req[9] = flags[SRC_NRX];
        slot_req[10] = flags[SRC_NTX];
        slot_req[11] = flags[SRC_S0E];
        slot_req[12] = flags[SRC_S0R];
        slot_req[13] = flags[SRC_S0T];
        slot_req[14] = flags[SRC_P2] | flags[SRC_CSI];
        slot_req[ISV_SLOTS-1:15] = flags[SRC_EXT +: ISV_SLOTS-15];
        slot_req = slot_req & ~mask;
    end

    // ****************************************
    // arbitration
    // ****************************************
    // in_service bit0: low group in service, bit1: high group in service
    logic found, win_low;
    logic [ISV_SLOT_W-1:0] win_slot;
    isv_arbiter u_arb (
        .req(slot_req),
        .prio_low(prio_low),
        .allow_high(int_enable && !in_service[1]),
        .allow_low(int_enable && in_service == ISV_NO_SERVICE),
        .found(found),
        .win_slot(win_slot),
        .win_low(win_low)
    );

    // ****************************************
    // offer to core
    // ****************************************
    isv_state_t state, next_state;
    isv_grant_t next_grant;
    logic [1:0] next_in_service;
    logic break_pend, next_break_pend;
    always_comb begin
        next_state = state;
        next_grant = grant;
        next_in_service = in_service;
        // break kept pending until offered, never lost to arbitration
        next_break_pend = break_pend | software_break_instr;
        if (service_done) begin
            // highest active level retires first
            if (in_service[1]) next_in_service[1] = 1'b0;
            else next_in_service[0] = 1'b0;
        end
        case (state)
            ISV_IDLE: begin
                if (|reset_src) begin
                    next_grant = '{1'b1, 1'b0, 1'b1, 1'b1, 5'h00, ISV_VEC_RESET};
                    next_state = ISV_OFFER;
                end else if (break_pend) begin
                    // bypasses enable and in-service state
                    next_grant = '{1'b1, 1'b1, 1'b0, 1'b0, 5'h00, ISV_VEC_BREAK};
                    next_break_pend = software_break_instr;
                    next_state = ISV_OFFER;
                end else if (found) begin
                    next_grant.valid = 1'b1;
                    next_grant.is_break = 1'b0;
                    next_grant.is_reset = 1'b0;
                    next_grant.high_group = !win_low;
                    next_grant.slot = win_slot;
                    next_grant.vector = ISV_VEC_BASE
                        + ISV_VEC_W'({win_slot, 1'b0});
                    next_state = ISV_OFFER;
                end
            end
            ISV_OFFER: begin
                if (ack) begin
                    if (!grant.is_break && !grant.is_reset) begin
                        if (grant.high_group) next_in_service[1] = 1'b1;
                        else next_in_service[0] = 1'b1;
                    end
                    next_grant.valid = 1'b0;
                    next_state = ISV_WAIT_ACK;
                end
            end
            ISV_WAIT_ACK: begin
                // one idle cycle lets the core clear the flag
                next_state = ISV_IDLE;
            end
            default: next_state = ISV_IDLE;
        endcase
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ISV_IDLE;
            grant <= '0;
            in_service <= ISV_NO_SERVICE;
            break_pend <= 1'b0;
        end else begin
            state <= next_state;
            grant <= next_grant;
            in_service <= next_in_service;
            break_pend <= next_break_pend;
        end
    end
endmodule // isv_top
